// ==== hw/two_wire_pkg.sv ====
`default_nettype none
// shared constants for both ends of the two-wire port
package two_wire_pkg;
	// core clock and bus clock timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int SCL_PERIOD_NS = 10000;
	// quarter of a bus clock period in core cycles, rounded down
	localparam int SCL_QTR_CYC   = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
	// framing
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [3:0] ACK_SLOT  = 4'h8;
	// direction bit encoding
	localparam logic DIR_WRITE = 1'b0;
	localparam logic DIR_READ  = 1'b1;
	// upper six address bits; value is arbitrary
	localparam logic [5:0] ADDR_HIGH_DFLT = 6'h24;
	// byte sent when the user queued nothing
	localparam logic [7:0] IDLE_FILL = 8'hFF;
endpackage
`default_nettype wire

// ==== hw/two_wire_if.sv ====
`default_nettype none
// open-drain bus wires; each end pulls low only, pull-ups assumed
interface two_wire_if;
	logic scl_m_o;   // master clock output level (always low)
	logic scl_m_oe;  // master pulls clock low
	logic sda_m_o;   // master data output level (always low)
	logic sda_m_oe;  // master pulls data low
	logic sda_s_o;   // slave data output level (always low)
	logic sda_s_oe;  // slave pulls data low
	logic scl;       // resolved clock level
	logic sda;       // resolved data level
	// wired-and resolution of the pins
	assign scl = ~(scl_m_oe & ~scl_m_o);
	assign sda = ~((sda_m_oe & ~sda_m_o) | (sda_s_oe & ~sda_s_o));
	modport master (output scl_m_o, scl_m_oe, sda_m_o, sda_m_oe,
		input scl, sda);
	modport slave (output sda_s_o, sda_s_oe, input scl, sda);
endinterface
`default_nettype wire

// ==== hw/two_wire_master_port.sv ====
`default_nettype none
// bus master end: makes the clock by dividing core_clk_i
module two_wire_master_port
	import two_wire_pkg::*;
#(
	parameter int QTR_CYC = two_wire_pkg::SCL_QTR_CYC
) (
	// clock and reset
	input  wire logic        core_clk_i,
	input  wire logic        srst_i,
	// bus side
	two_wire_if.master       bus,
	// byte commands
	input  wire logic        cmd_valid_i,
	output logic             cmd_ready_o,
	input  wire logic        cmd_start_i,
	input  wire logic        cmd_stop_i,
	input  wire logic        cmd_read_i,
	input  wire logic        cmd_nack_i,
	input  wire logic [7:0]  cmd_data_i,
	// byte results
	output logic             res_valid_o,
	output logic [7:0]       res_data_o,
	output logic             res_nack_o
);
	import two_wire_pkg::*;

	typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} hstate_t;

	////////////////////////////////////////////////////////////////////
	// pull-low decision for one bit slot, msb first
	function automatic logic drive_low(input logic [3:0] slot,
		input logic [7:0] sh, input logic rd, input logic nack);
		if (slot == ACK_SLOT)
			drive_low = rd & ~nack;
		else
			drive_low = ~rd & ~sh[7];
	endfunction

	////////////////////////////////////////////////////////////////////
	hstate_t     st_q, st_d;       // sequencer state
	logic [15:0] qc_q, qc_d;       // quarter-period counter
	logic [1:0]  ph_q, ph_d;       // quarter within a slot
	logic [3:0]  bit_q, bit_d;     // slot index, 8 is ack
	logic [7:0]  sh_q, sh_d;       // shift register
	logic        rd_q, rd_d;       // read byte
	logic        nk_q, nk_d;       // answer read with not-ack
	logic        sp_q, sp_d;       // stop after byte
	logic        ak_q, ak_d;       // sampled ack slot
	logic        scl_q, scl_d;     // pulling clock low
	logic        sda_q, sda_d;     // pulling data low
	logic        rdy_q, rdy_d;     // command ready
	logic        rv_q, rv_d;       // result pulse
	logic [1:0]  sda_s_q;          // data pin synchroniser
	logic        tick;             // end of a quarter

	assign tick = (qc_q == 16'(QTR_CYC - 1));

	// open-drain pins only ever pull low
	assign bus.scl_m_o  = 1'b0;
	assign bus.sda_m_o  = 1'b0;
	assign bus.scl_m_oe = scl_q;
	assign bus.sda_m_oe = sda_q;
	assign cmd_ready_o  = rdy_q;
	assign res_valid_o  = rv_q;
	assign res_data_o   = sh_q;
	assign res_nack_o   = ak_q;

	// pin synchroniser, two stages before use
	always_ff @(posedge core_clk_i) begin
		sda_s_q <= {sda_s_q[0], bus.sda};
	end

	////////////////////////////////////////////////////////////////////
	// sequencer: all clock pulses and conditions come from here
	always_comb begin
		st_d = st_q;
		qc_d = tick ? 16'h0000 : qc_q + 16'h0001;
		ph_d = tick ? ph_q + 2'h1 : ph_q;
		bit_d = bit_q;
		sh_d = sh_q;
		rd_d = rd_q;
		nk_d = nk_q;
		sp_d = sp_q;
		ak_d = ak_q;
		scl_d = scl_q;
		sda_d = sda_q;
		rdy_d = rdy_q;
		rv_d = 1'b0;
		case (st_q)
			H_IDLE: begin
				qc_d = 16'h0000;
				ph_d = 2'h0;
				rdy_d = 1'b1;
				if (cmd_valid_i && rdy_q) begin
					rdy_d = 1'b0;
					sh_d = cmd_data_i;
					rd_d = cmd_read_i;
					nk_d = cmd_nack_i;
					sp_d = cmd_stop_i;
					bit_d = 4'h0;
					if (cmd_start_i) begin
						// release data, keep clock as it is
						st_d = H_START;
						sda_d = 1'b0;
					end else begin
						// bus held: clock low, first bit now
						st_d = H_BIT;
						sda_d = drive_low(4'h0, cmd_data_i,
							cmd_read_i, cmd_nack_i);
					end
				end
			end
			H_START: begin
				// also a repeated start when the bus is held
				if (tick) begin
					case (ph_q)
						2'h0: scl_d = 1'b0;
						2'h1: sda_d = 1'b1;
						2'h2: scl_d = 1'b1;
						default: begin
							st_d = H_BIT;
							sda_d = drive_low(4'h0, sh_q, rd_q, nk_q);
						end
					endcase
				end
			end
			H_BIT: begin
				if (tick) begin
					case (ph_q)
						2'h0: scl_d = 1'b0;
						2'h1: begin
							// sample in the middle of the high phase
							if (bit_q == ACK_SLOT)
								ak_d = sda_s_q[1];
							else
								sh_d = {sh_q[6:0], sda_s_q[1]};
						end
						2'h2: scl_d = 1'b1;
						default: begin
							if (bit_q == ACK_SLOT) begin
								rv_d = 1'b1;
								if (sp_q) begin
									st_d = H_STOP;
									sda_d = 1'b1;
								end else begin
									st_d = H_IDLE;
									sda_d = 1'b0;
								end
							end else begin
								bit_d = bit_q + 4'h1;
								sda_d = drive_low(bit_q + 4'h1, sh_q,
									rd_q, nk_q);
							end
						end
					endcase
				end
			end
			H_STOP: begin
				if (tick) begin
					case (ph_q)
						2'h0: scl_d = 1'b0;
						2'h1: sda_d = 1'b0;
						2'h2: sda_d = 1'b0;
						default: st_d = H_IDLE;
					endcase
				end
			end
			default: st_d = H_IDLE;
		endcase
	end

	// sequencer registers
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			st_q <= H_IDLE;
			qc_q <= 16'h0000;
			ph_q <= 2'h0;
			bit_q <= 4'h0;
			sh_q <= 8'h00;
			rd_q <= 1'b0;
			nk_q <= 1'b0;
			sp_q <= 1'b0;
			ak_q <= 1'b0;
			scl_q <= 1'b0;
			sda_q <= 1'b0;
			rdy_q <= 1'b0;
			rv_q <= 1'b0;
		end else begin
			st_q <= st_d;
			qc_q <= qc_d;
			ph_q <= ph_d;
			bit_q <= bit_d;
			sh_q <= sh_d;
			rd_q <= rd_d;
			nk_q <= nk_d;
			sp_q <= sp_d;
			ak_q <= ak_d;
			scl_q <= scl_d;
			sda_q <= sda_d;
			rdy_q <= rdy_d;
			rv_q <= rv_d;
		end
	end
endmodule
`default_nettype wire

// ==== hw/two_wire_slave_port.sv ====
`default_nettype none
// How it works
// - master sends address byte, then data bytes
// - device acknowledges each received data byte unless the previous one is still pending
// - bytes travel most significant bit first
// - read: device streams bytes while master continues
// - master acks all read bytes except last
// - master makes every clock pulse and condition
// - repeated start begins a new transfer
// - first byte: seven address bits plus direction
// - address lsb follows the address select pin
// - direction 0 writes, 1 reads
// - matching address acked in either direction
// - start begins, stop ends a transfer
// - transmit bits change on received clock
// - start/stop are data edges while clock high
// - ack holds data low whole high phase
// - release data after master not-acknowledge
module two_wire_slave_port
	import two_wire_pkg::*;
#(
	parameter logic [5:0] ADDR_HIGH = two_wire_pkg::ADDR_HIGH_DFLT
) (
	// clocks and reset
	input  wire logic        core_clk_i,
	input  wire logic        srst_i,
	input  wire logic        link_clk_i,
	// bus side
	two_wire_if.slave        bus,
	input  wire logic        address_select_pin_i,
	// bytes written by the master
	output logic [7:0]       rx_data_o,
	output logic             rx_valid_o,
	input  wire logic        rx_ready_i,
	// bytes to be read by the master
	input  wire logic [7:0]  tx_data_i,
	input  wire logic        tx_valid_i,
	output logic             tx_ready_o
);
	import two_wire_pkg::*;

	typedef enum logic [2:0] {L_IDLE, L_RECV, L_RACK, L_SEND, L_MACK} lstate_t;

	////////////////////////////////////////////////////////////////////
	// link domain declarations
	logic [1:0] rst_s_q;           // reset carried into link domain
	logic       link_rst;          // link domain reset
	logic [1:0] scl_s_q;           // clock pin synchroniser
	logic [1:0] sda_s_q;           // data pin synchroniser
	logic [1:0] sel_s_q;           // select pin synchroniser
	logic [1:0] rxa_s_q;           // rx ack toggle synchroniser
	logic [1:0] txr_s_q;           // tx request toggle synchroniser
	logic       scl_p_q, scl_p_d;  // previous clock level
	logic       sda_p_q, sda_p_d;  // previous data level
	lstate_t    ls_q, ls_d;        // bit engine state
	logic [3:0] cnt_q, cnt_d;      // clock rises in this byte
	logic [7:0] sh_q, sh_d;        // shift register
	logic       adr_q, adr_d;      // byte is the address
	logic       dir_q, dir_d;      // transfer direction
	logic       oe_q, oe_d;        // pulling data low
	logic       mnk_q, mnk_d;      // master answered not-ack
	logic [7:0] rxb_q, rxb_d;      // byte handed to core
	logic       rxr_q, rxr_d;      // rx request toggle
	logic [7:0] txb_q, txb_d;      // byte waiting to be sent
	logic       txh_q, txh_d;      // txb_q holds a byte
	logic       txa_q, txa_d;      // tx ack toggle
	logic       txn_q, txn_d;      // last tx request seen
	logic       start_ev;          // start or repeated start
	logic       stop_ev;           // stop
	logic       scl_rise;          // clock rising
	logic       scl_fall;          // clock falling
	logic       rx_busy;           // previous byte not yet taken
	logic       load_tx;           // fetch next byte to send

	// core domain declarations
	logic [1:0] rxr_s_q;           // rx request toggle synchroniser
	logic [1:0] txa_s_q;           // tx ack toggle synchroniser
	logic       rxn_q, rxn_d;      // last rx request seen
	logic       rxp_q, rxp_d;      // rx byte pending in link
	logic       rxa_q, rxa_d;      // rx ack toggle
	logic       ov_q, ov_d;        // output slot valid
	logic [7:0] od_q, od_d;        // output slot data
	logic       sv_q, sv_d;        // spare slot valid
	logic [7:0] sd_q, sd_d;        // spare slot data
	logic [7:0] txd_q, txd_d;      // tx byte held for crossing
	logic       txr_q, txr_d;      // tx request toggle
	logic       trd_q, trd_d;      // tx holding register free

	assign bus.sda_s_o  = 1'b0;
	assign bus.sda_s_oe = oe_q;
	assign rx_data_o    = od_q;
	assign rx_valid_o   = ov_q;
	assign tx_ready_o   = trd_q;
	assign link_rst     = rst_s_q[1];

	////////////////////////////////////////////////////////////////////
	// synchronisers into the link domain
	always_ff @(posedge link_clk_i) begin
		rst_s_q <= {rst_s_q[0], srst_i};
		scl_s_q <= {scl_s_q[0], bus.scl};
		sda_s_q <= {sda_s_q[0], bus.sda};
		sel_s_q <= {sel_s_q[0], address_select_pin_i};
		rxa_s_q <= {rxa_s_q[0], rxa_q};
		txr_s_q <= {txr_s_q[0], txr_q};
	end

	// bus events seen on the sampled pins
	assign start_ev = scl_s_q[1] & sda_p_q & ~sda_s_q[1];
	assign stop_ev  = scl_s_q[1] & ~sda_p_q & sda_s_q[1];
	assign scl_rise = scl_s_q[1] & ~scl_p_q;
	assign scl_fall = ~scl_s_q[1] & scl_p_q;
	assign rx_busy  = rxr_q ^ rxa_s_q[1];

	////////////////////////////////////////////////////////////////////
	// bit engine; data only changes after a clock fall
	always_comb begin
		scl_p_d = scl_s_q[1];
		sda_p_d = sda_s_q[1];
		ls_d = ls_q;
		cnt_d = cnt_q;
		sh_d = sh_q;
		adr_d = adr_q;
		dir_d = dir_q;
		oe_d = oe_q;
		mnk_d = mnk_q;
		rxb_d = rxb_q;
		rxr_d = rxr_q;
		txb_d = txb_q;
		txh_d = txh_q;
		txa_d = txa_q;
		txn_d = txn_q;
		load_tx = 1'b0;
		case (ls_q)
			L_IDLE: begin
				// released, waiting for a start
				oe_d = 1'b0;
			end
			L_RECV: begin
				if (scl_rise) begin
					sh_d = {sh_q[6:0], sda_s_q[1]};
					cnt_d = cnt_q + 4'h1;
				end
				if (scl_fall && cnt_q == BYTE_BITS) begin
					if (adr_q) begin
						// seven address bits, then direction
						if (sh_q[7:1] == {ADDR_HIGH, sel_s_q[1]}) begin
							oe_d = 1'b1;
							dir_d = sh_q[0];
							ls_d = L_RACK;
						end else begin
							ls_d = L_IDLE;
						end
					end else begin
						// data byte; a byte the core has not taken
						// yet blocks this one and it is not acked
						if (!rx_busy) begin
							rxb_d = sh_q;
							rxr_d = ~rxr_q;
							oe_d = 1'b1;
						end
						ls_d = L_RACK;
					end
				end
			end
			L_RACK: begin
				// low held across the whole ack pulse
				if (scl_fall) begin
					oe_d = 1'b0;
					adr_d = 1'b0;
					cnt_d = 4'h0;
					if (dir_q == DIR_READ)
						load_tx = 1'b1;
					else
						ls_d = L_RECV;
				end
			end
			L_SEND: begin
				if (scl_rise)
					cnt_d = cnt_q + 4'h1;
				if (scl_fall) begin
					if (cnt_q == BYTE_BITS) begin
						oe_d = 1'b0;
						ls_d = L_MACK;
					end else begin
						sh_d = {sh_q[6:0], 1'b1};
						oe_d = ~sh_q[6];
					end
				end
			end
			L_MACK: begin
				if (scl_rise)
					mnk_d = sda_s_q[1];
				if (scl_fall) begin
					if (mnk_q)
						ls_d = L_IDLE;
					else
						load_tx = 1'b1;
				end
			end
			default: ls_d = L_IDLE;
		endcase
		// next byte out: queued byte or filler, first bit at once
		if (load_tx) begin
			sh_d = txh_q ? txb_q : IDLE_FILL;
			txh_d = 1'b0;
			oe_d = txh_q ? ~txb_q[7] : ~IDLE_FILL[7];
			cnt_d = 4'h0;
			ls_d = L_SEND;
		end
		// take a new tx byte only once the last one is used up
		if ((txr_s_q[1] ^ txn_q) && !txh_q) begin
			txb_d = txd_q;
			txh_d = 1'b1;
			txn_d = txr_s_q[1];
			txa_d = ~txa_q;
		end
		// conditions override the byte engine
		if (start_ev) begin
			ls_d = L_RECV;
			cnt_d = 4'h0;
			adr_d = 1'b1;
			oe_d = 1'b0;
		end else if (stop_ev) begin
			ls_d = L_IDLE;
			oe_d = 1'b0;
		end
	end

	// bit engine registers
	always_ff @(posedge link_clk_i) begin
		if (link_rst) begin
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
			ls_q <= L_IDLE;
			cnt_q <= 4'h0;
			sh_q <= 8'h00;
			adr_q <= 1'b0;
			dir_q <= DIR_WRITE;
			oe_q <= 1'b0;
			mnk_q <= 1'b0;
			rxb_q <= 8'h00;
			rxr_q <= 1'b0;
			txb_q <= 8'h00;
			txh_q <= 1'b0;
			txa_q <= 1'b0;
			txn_q <= 1'b0;
		end else begin
			scl_p_q <= scl_p_d;
			sda_p_q <= sda_p_d;
			ls_q <= ls_d;
			cnt_q <= cnt_d;
			sh_q <= sh_d;
			adr_q <= adr_d;
			dir_q <= dir_d;
			oe_q <= oe_d;
			mnk_q <= mnk_d;
			rxb_q <= rxb_d;
			rxr_q <= rxr_d;
			txb_q <= txb_d;
			txh_q <= txh_d;
			txa_q <= txa_d;
			txn_q <= txn_d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// synchronisers into the core domain
	always_ff @(posedge core_clk_i) begin
		rxr_s_q <= {rxr_s_q[0], rxr_q};
		txa_s_q <= {txa_s_q[0], txa_q};
	end

	// two-entry rx buffer and tx holding register
	always_comb begin
		rxn_d = rxn_q;
		rxp_d = rxp_q;
		rxa_d = rxa_q;
		ov_d = ov_q;
		od_d = od_q;
		sv_d = sv_q;
		sd_d = sd_q;
		txd_d = txd_q;
		txr_d = txr_q;
		trd_d = trd_q;
		// drain or refill the output slot
		if (!ov_q || rx_ready_i) begin
			ov_d = sv_q;
			od_d = sd_q;
			sv_d = 1'b0;
		end
		// push only into a free spare so a stall backs up the link
		if (rxp_q && !sv_q) begin
			if (!ov_d) begin
				ov_d = 1'b1;
				od_d = rxb_q;
			end else begin
				sv_d = 1'b1;
				sd_d = rxb_q;
			end
			rxp_d = 1'b0;
			rxa_d = ~rxa_q;
		end
		// new byte from the link, after the push so the set wins;
		// rxb_q is stable until acked
		if (rxr_s_q[1] ^ rxn_q) begin
			rxp_d = 1'b1;
			rxn_d = rxr_s_q[1];
		end
		// tx byte crosses by request toggle, freed by the ack
		if (tx_valid_i && trd_q) begin
			txd_d = tx_data_i;
			txr_d = ~txr_q;
			trd_d = 1'b0;
		end else if (!trd_q && txa_s_q[1] == txr_q) begin
			trd_d = 1'b1;
		end
	end

	// core domain registers
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			rxn_q <= 1'b0;
			rxp_q <= 1'b0;
			rxa_q <= 1'b0;
			ov_q <= 1'b0;
			od_q <= 8'h00;
			sv_q <= 1'b0;
			sd_q <= 8'h00;
			txd_q <= 8'h00;
			txr_q <= 1'b0;
			trd_q <= 1'b0;
		end else begin
			rxn_q <= rxn_d;
			rxp_q <= rxp_d;
			rxa_q <= rxa_d;
			ov_q <= ov_d;
			od_q <= od_d;
			sv_q <= sv_d;
			sd_q <= sd_d;
			txd_q <= txd_d;
			txr_q <= txr_d;
			trd_q <= trd_d;
		end
	end
endmodule
`default_nettype wire

// ==== testbench/two_wire_assertions.sv ====
`default_nettype none
// watches the shared wires, sampled by the core clock
module two_wire_assertions
	import two_wire_pkg::*;
#(
	parameter logic [5:0] ADDR_HIGH = two_wire_pkg::ADDR_HIGH_DFLT
) (
	// clock, reset and address pin
	input  wire logic core_clk_i,
	input  wire logic srst_i,
	input  wire logic address_select_pin_i,
	// bus wires
	input  wire logic sda_m_oe,
	input  wire logic sda_s_oe,
	input  wire logic scl,
	input  wire logic sda
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (srst_i);
	////////////////////////////////////////////////////////////////////
	logic       scl_q;   // clock level last cycle
	logic       sda_q;   // data level last cycle
	logic [3:0] cnt_q;   // slot index within the byte
	logic [3:0] cnt_d;
	logic [7:0] sh_q;    // bits seen in this byte
	logic [7:0] sh_d;
	logic       first_q; // inside the address byte
	logic       first_d;
	logic       own_q;   // device was addressed
	logic       own_d;
	logic       rd_q;    // transfer is a read
	logic       rd_d;
	logic       start;   // data fell, clock high
	logic       stop;    // data rose, clock high
	logic       rise;    // clock rising
	logic       slot8;   // rising edge of the ack slot
	logic       match;   // address byte names the device
	assign start = scl & scl_q & sda_q & ~sda;
	assign stop  = scl & scl_q & ~sda_q & sda;
	assign rise  = scl & ~scl_q;
	assign slot8 = rise & (cnt_q == ACK_SLOT);
	assign match = (sh_q[7:1] == {ADDR_HIGH, address_select_pin_i});
	// next values of the bus tracker
	always_comb begin
		cnt_d   = cnt_q;
		sh_d    = sh_q;
		first_d = first_q;
		own_d   = own_q;
		rd_d    = rd_q;
		if (rise) begin
			cnt_d = (cnt_q == ACK_SLOT) ? 4'h0 : cnt_q + 4'h1;
			if (cnt_q != ACK_SLOT)
				sh_d = {sh_q[6:0], sda};
		end
		// address byte decides ownership and direction
		if (slot8 && first_q) begin
			first_d = 1'b0;
			own_d   = match;
			rd_d    = sh_q[0];
		end
		// a not-ack from the master ends the read
		if (slot8 && !first_q && rd_q && sda)
			own_d = 1'b0;
		// conditions restart the tracker
		if (start || stop) begin
			cnt_d   = 4'h0;
			first_d = start;
			own_d   = 1'b0;
		end
	end
	// tracker registers, idle bus under reset
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			scl_q   <= 1'b1;
			sda_q   <= 1'b1;
			cnt_q   <= 4'h0;
			sh_q    <= 8'h00;
			first_q <= 1'b0;
			own_q   <= 1'b0;
			rd_q    <= 1'b0;
		end else begin
			scl_q   <= scl;
			sda_q   <= sda;
			cnt_q   <= cnt_d;
			sh_q    <= sh_d;
			first_q <= first_d;
			own_q   <= own_d;
			rd_q    <= rd_d;
		end
	end
	////////////////////////////////////////////////////////////////////
	drive_stable_a:
	assert property (scl && $past(scl) |-> $stable(sda_s_oe))
		else $error("device data moved while clock high");
	start_master_a:
	assert property (scl && $past(scl) && $fell(sda) |-> sda_m_oe)
		else $error("start not made by the master");
	stop_master_a:
	assert property (scl && $past(scl) && $rose(sda) |-> $past(sda_m_oe))
		else $error("stop not made by the master");
	addr_ack_a:
	assert property (slot8 && first_q && match |-> sda_s_oe && !sda)
		else $error("matching address not acknowledged");
	addr_ignore_a:
	assert property (slot8 && first_q && !match |-> !sda_s_oe)
		else $error("foreign address acknowledged");
	idle_released_a:
	assert property (!own_q && !(first_q && cnt_q == ACK_SLOT) |-> !sda_s_oe)
		else $error("device drives data while not addressed");
	rx_bits_free_a:
	assert property (own_q && !rd_q && cnt_q != 4'h0 && cnt_q != ACK_SLOT
		|-> !sda_s_oe)
		else $error("device drives data bits of a write");
	tx_ack_free_a:
	assert property (own_q && rd_q && slot8 |-> !sda_s_oe)
		else $error("device holds data in the master ack slot");
	tx_bus_a:
	assert property (own_q && rd_q && rise && cnt_q != ACK_SLOT
		|-> sda == !sda_s_oe)
		else $error("read bit not set by the device alone");
	// main scenarios
	cover property (slot8 && own_q && !rd_q && !sda);
	cover property (slot8 && own_q && rd_q && sda);
	cover property (start && own_q);
	cover property (slot8 && first_q && !match);
endmodule
`default_nettype wire

// ==== testbench/two_wire_slave_port_tb.sv ====
`default_nettype none
// master end and device end face each other across the wires
module two_wire_slave_port_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import two_wire_pkg::*;
	localparam int QTR = 80;        // shortest quarter the link sync allows
	localparam int LIMIT = 95000;   // cycles the run may take
	localparam logic [5:0] AH = ADDR_HIGH_DFLT;
	////////////////////////////////////////////////////////////////////
	logic       core_clk_i = 1'b0;  // core clock
	logic       link_clk_i;         // device link clock
	logic       srst_i = 1'b1;      // shared reset
	logic       cmd_valid = 1'b0;   // master command port
	logic       cmd_ready;
	logic       cmd_start = 1'b0;
	logic       cmd_stop = 1'b0;
	logic       cmd_read = 1'b0;
	logic       cmd_nack = 1'b0;
	logic [7:0] cmd_data = 8'h00;
	logic       res_valid;          // master results
	logic [7:0] res_data;
	logic       res_nack;
	logic       pin = 1'b0;         // address select level
	logic [7:0] rx_data;            // device write stream
	logic       rx_valid;
	logic       rx_ready = 1'b0;    // held low: receiver stalls
	logic [7:0] tx_data = 8'h00;    // device read stream
	logic       tx_valid = 1'b0;
	logic       tx_ready;
	int         mismatches = 0;
	int         n_checks = 0;
	int         cycles = 0;
	int         n;                  // bytes the buffer took
	logic [7:0] wr [5] = '{8'hA5, 8'h3C, 8'h81, 8'h96, 8'h5A};
	logic [6:0] adr [3] = '{{AH, 1'b0}, {AH ^ 6'h01, 1'b1}, {AH, 1'b1}};
	////////////////////////////////////////////////////////////////////
	always #5 core_clk_i = ~core_clk_i;
	// link clock, offset so its phase is unrelated
	initial begin
		link_clk_i = 1'b0;
		#33;
		forever #80 link_clk_i = ~link_clk_i;
	end
	two_wire_if i_two_wire_if ();
	two_wire_master_port #(.QTR_CYC(QTR)) i_two_wire_master_port (
		.core_clk_i(core_clk_i), .srst_i(srst_i), .bus(i_two_wire_if),
		.cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready),
		.cmd_start_i(cmd_start), .cmd_stop_i(cmd_stop),
		.cmd_read_i(cmd_read), .cmd_nack_i(cmd_nack),
		.cmd_data_i(cmd_data), .res_valid_o(res_valid),
		.res_data_o(res_data), .res_nack_o(res_nack));
	two_wire_slave_port #(.ADDR_HIGH(AH)) i_two_wire_slave_port (
		.core_clk_i(core_clk_i), .srst_i(srst_i),
		.link_clk_i(link_clk_i), .bus(i_two_wire_if),
		.address_select_pin_i(pin), .rx_data_o(rx_data),
		.rx_valid_o(rx_valid), .rx_ready_i(rx_ready),
		.tx_data_i(tx_data), .tx_valid_i(tx_valid), .tx_ready_o(tx_ready));
	two_wire_assertions #(.ADDR_HIGH(AH)) i_two_wire_assertions (
		.core_clk_i(core_clk_i), .srst_i(srst_i),
		.address_select_pin_i(pin),
		.sda_m_oe(i_two_wire_if.sda_m_oe),
		.sda_s_oe(i_two_wire_if.sda_s_oe),
		.scl(i_two_wire_if.scl), .sda(i_two_wire_if.sda));
	////////////////////////////////////////////////////////////////////
	// counts and reports one comparison
	task automatic check(input string what, input logic [7:0] seen,
		input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// one byte on the bus, held until taken, then wait for its result
	task automatic cmd(input int s, p, r, k, input logic [7:0] d);
		@(negedge core_clk_i);
		while (cmd_ready !== 1'b1) @(negedge core_clk_i);
		{cmd_start, cmd_stop, cmd_read, cmd_nack} = {s[0], p[0], r[0], k[0]};
		cmd_data  = d;
		cmd_valid = 1'b1;
		@(negedge core_clk_i);
		cmd_valid = 1'b0;
		while (res_valid !== 1'b1) @(negedge core_clk_i);
	endtask
	// queue a byte for the master to read
	task automatic push(input logic [7:0] d);
		@(negedge core_clk_i);
		tx_data  = d;
		tx_valid = 1'b1;
		while (tx_ready !== 1'b1) @(negedge core_clk_i);
		@(negedge core_clk_i);
		tx_valid = 1'b0;
	endtask
	// take one written byte and compare it
	task automatic pop(input logic [7:0] exp);
		@(negedge core_clk_i);
		while (rx_valid !== 1'b1) @(negedge core_clk_i);
		check("rx byte", rx_data, exp);
		rx_ready = 1'b1;
		@(negedge core_clk_i);
		rx_ready = 1'b0;
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// watchdog: a hang counts as a mismatch
	always @(posedge core_clk_i) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			mismatches++;
			stop_test();
		end
	end
	////////////////////////////////////////////////////////////////////
	initial begin
		// long enough for four link edges, not just two core cycles
		repeat (70) @(negedge core_clk_i);
		srst_i = 1'b0;
		repeat (120) @(negedge core_clk_i);
		check("idle wires", {6'h0, i_two_wire_if.scl, i_two_wire_if.sda},
			8'h03);
		// writes while the receiver stalls, until the buffer refuses
		cmd(1, 0, 0, 0, {AH, 1'b0, DIR_WRITE});
		check("write addr", {7'h0, res_nack}, 8'h00);
		n = 0;
		for (int k = 0; k < 5; k++) begin
			cmd(0, 0, 0, 0, wr[k]);
			if (res_nack) break;
			n++;
		end
		check("refused", {7'h0, res_nack}, 8'h01);
		// two buffer slots plus the byte waiting in the link
		check("kept three", 8'(n), 8'h03);
		for (int k = 0; k < n; k++)
			pop(wr[k]);
		cmd(0, 1, 0, 0, 8'h69);
		check("after drain", {7'h0, res_nack}, 8'h00);
		pop(8'h69);
		// read two bytes, not-ack the last, restart as a write
		push(8'hC3);
		push(8'h5A);
		cmd(1, 0, 0, 0, {AH, 1'b0, DIR_READ});
		check("read addr", {7'h0, res_nack}, 8'h00);
		cmd(0, 0, 1, 0, 8'hFF);
		check("read 1", res_data, 8'hC3);
		cmd(0, 0, 1, 1, 8'hFF);
		check("read 2", res_data, 8'h5A);
		cmd(1, 0, 0, 0, {AH, 1'b0, DIR_WRITE});
		check("restart", {7'h0, res_nack}, 8'h00);
		cmd(0, 1, 0, 0, 8'h96);
		pop(8'h96);
		// nothing queued: filler byte, then release for stop
		cmd(1, 0, 0, 0, {AH, 1'b0, DIR_READ});
		cmd(0, 1, 1, 1, 8'hFF);
		check("filler", res_data, IDLE_FILL);
		// select pin high moves the address
		pin = 1'b1;
		repeat (100) @(negedge core_clk_i);
		for (int k = 0; k < 3; k++) begin
			cmd(1, 1, 0, 0, {adr[k], DIR_WRITE});
			check("addr", {7'h0, res_nack}, {7'h0, k != 2});
		end
		// foreign address: data after it is ignored
		cmd(1, 0, 0, 0, {AH, 1'b0, DIR_WRITE});
		cmd(0, 1, 0, 0, 8'h5A);
		check("ignored", {7'h0, res_nack}, 8'h01);
		check("no rx", {7'h0, rx_valid}, 8'h00);
		stop_test();
	end
endmodule
`default_nettype wire
